/* File: common/edge_if.sv */
// Interface between the scan logic top and its edge tracker.
interface edge_if;
	import scan_logic_pkg::*;
	logic [NUM_CH-1:0] point;
	logic [NUM_CH-1:0] retentive;
	logic              scan;
	logic              run_entry;
	logic [NUM_CH-1:0] rise;
	logic [NUM_CH-1:0] fall;

	modport tracker (
		input  point,
		input  retentive,
		input  scan,
		input  run_entry,
		output rise,
		output fall
	);
	modport user (
		output point,
		output retentive,
		output scan,
		output run_entry,
		input  rise,
		input  fall
	);
endinterface

/* File: common/scan_logic_pkg.sv */
// Shared constants and types for the scan edge, latch and pause logic.
// Operation
// - Start rise contact closes one scan
// - Retentive point on at run entry pulses
// - Start fall contact closes one scan
// - Parallel rise contact ORs with branch
// - Parallel fall contact ORs with branch
// - Series rise contact ANDs with preceding logic
// - Series fall contact ANDs with preceding logic
// - Latch set turns on point or range
// - Set point stays on until reset
// - Latch reset clears point or range, stays
// - Word bit set, BCD index 0 to 15
// - Word bit reset clears bit, stays clear
// - Pause blanks outputs, image keeps updating
// - Override exempts chosen outputs from pause
package scan_logic_pkg;
	localparam int NUM_CH     = 8;
	localparam int NUM_POINTS = 64;
	localparam int PT_W       = 6;
	localparam int NUM_WORDS  = 8;
	localparam int WORD_IDX_W = 3;
	localparam int WORD_W     = 16;
	localparam int BCD_W      = 8;
	localparam int BIT_IDX_W  = 4;
	localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
	localparam logic [3:0] BCD_TENS_MAX  = 4'h1;
	localparam logic [3:0] BCD_UNITS_MAX = 4'h5;
	localparam logic [3:0] BCD_TEN       = 4'ha;
	localparam int         BCD_DIGIT_W   = 4;
	localparam logic [3:0] BCD_ZERO      = 4'h0;
	localparam logic [NUM_POINTS-1:0] POINTS_RESET = '0;
	localparam logic [WORD_W-1:0]     WORD_RESET   = '0;

	// Where an edge contact sits in its rung
	typedef enum logic [2:0] {
		KIND_START    = 3'b001,
		KIND_PARALLEL = 3'b010,
		KIND_SERIES   = 3'b100
	} contact_kind_type;

	// Operand class of a latch operation
	typedef enum logic [5:0] {
		PT_OUTPUT  = 6'b000001,
		PT_RELAY   = 6'b000010,
		PT_STAGE   = 6'b000100,
		PT_TIMER   = 6'b001000,
		PT_COUNTER = 6'b010000,
		PT_INPUT   = 6'b100000
	} point_class_type;
endpackage

/* File: rtl/edge_tracker.sv */
// Per-contact previous-scan memory and edge detection.
module edge_tracker (
	input wire logic clk,
	input wire logic rst_n,
	edge_if.tracker  e
);
	import scan_logic_pkg::*;

	logic [NUM_CH-1:0] prev_reg;

	// Remember each point's state as of the last scan
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_reg <= '0;
		end else if (e.scan) begin
			prev_reg <= e.point;
		end
	end

	// Edges compare this scan with the stored one
	genvar i;
	generate
		for (i = 0; i < NUM_CH; i++) begin : g_edge
			// A retentive point already on counts as a fresh rise at run entry
			assign e.rise[i] = (e.point[i] & ~prev_reg[i])
				| (e.run_entry & e.retentive[i] & e.point[i]);
			assign e.fall[i] = ~e.point[i] & prev_reg[i];
		end
	endgenerate
endmodule

/* File: rtl/scan_logic.sv */
// Scan-synchronous edge contacts, latches, word bits and output pause.
module scan_logic (
	input  wire logic                                 clk,
	input  wire logic                                 rst_n,
	input  wire logic                                 scan_tick,
	input  wire logic                                 run_mode,
	input  wire logic [scan_logic_pkg::NUM_CH-1:0]    ch_point,
	input  wire logic [scan_logic_pkg::NUM_CH-1:0]    ch_fall_sel,
	input  wire logic [scan_logic_pkg::NUM_CH-1:0]    ch_branch,
	input  wire logic [scan_logic_pkg::NUM_CH-1:0]    ch_retentive,
	input  scan_logic_pkg::contact_kind_type          ch_kind [scan_logic_pkg::NUM_CH],
	output logic      [scan_logic_pkg::NUM_CH-1:0]    contact_out,
	input  wire logic                                 latch_valid,
	input  wire logic                                 latch_set,
	input  scan_logic_pkg::point_class_type           latch_class,
	input  wire logic [scan_logic_pkg::PT_W-1:0]      latch_start,
	input  wire logic [scan_logic_pkg::PT_W-1:0]      latch_end,
	input  wire logic [scan_logic_pkg::NUM_POINTS-1:0] input_mapped,
	output logic      [scan_logic_pkg::NUM_POINTS-1:0] point_state,
	output logic                                      latch_reject,
	input  wire logic                                 wbit_valid,
	input  wire logic                                 wbit_set,
	input  wire logic [scan_logic_pkg::WORD_IDX_W-1:0] wbit_word,
	input  wire logic [scan_logic_pkg::BCD_W-1:0]     wbit_bcd,
	output logic      [scan_logic_pkg::WORD_W-1:0]    word_data [scan_logic_pkg::NUM_WORDS],
	output logic                                      wbit_reject,
	input  wire logic                                 pause_rung,
	input  wire logic [scan_logic_pkg::PT_W-1:0]      pause_start,
	input  wire logic [scan_logic_pkg::PT_W-1:0]      pause_end,
	input  wire logic [scan_logic_pkg::NUM_POINTS-1:0] pause_override,
	output logic      [scan_logic_pkg::NUM_POINTS-1:0] phys_out
);
	import scan_logic_pkg::*;

	// All inputs come from program evaluation logic on this clock, so
	// none of them is synchronised here.

	edge_if ed ();

	logic                  run_mode_reg;
	logic                  run_pending_reg;
	logic                  run_rise;
	logic [NUM_CH-1:0]     contact_reg;
	logic [NUM_CH-1:0]     contact_next;
	logic [NUM_POINTS-1:0] point_reg;
	logic [NUM_POINTS-1:0] latch_mask;
	logic [NUM_POINTS-1:0] set_allow;
	logic [NUM_POINTS-1:0] pause_mask;
	logic [NUM_POINTS-1:0] phys_reg;
	logic                  latch_reject_reg;
	logic                  class_refused;
	logic [WORD_W-1:0]     word_reg [NUM_WORDS];
	logic                  wbit_reject_reg;
	logic [3:0]            bcd_tens;
	logic [3:0]            bcd_units;
	logic                  bcd_ok;
	logic [BIT_IDX_W-1:0]  bit_idx;
	logic [NUM_CH-1:0]     edge_hit;
	logic [NUM_POINTS-1:0] hold_off;
	logic [NUM_POINTS-1:0] phys_next;
	logic                  wbit_go;
	logic [WORD_W-1:0]     bit_sel;
	logic [NUM_WORDS-1:0]  word_hit;

	edge_tracker u_edge (
		.clk   (clk),
		.rst_n (rst_n),
		.e     (ed.tracker)
	);

	// Feed the tracker with the current scan's point states
	assign ed.point     = ch_point;
	assign ed.retentive = ch_retentive;
	assign ed.scan      = scan_tick;
	assign ed.run_entry = run_pending_reg | run_rise;

	// Program-to-run change is noticed here and held until the next scan
	assign run_rise = run_mode & ~run_mode_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_mode_reg <= 1'b0;
		end else begin
			run_mode_reg <= run_mode;
		end
	end

	// A rise landing on a scan is used by that scan and not held for the next one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_pending_reg <= 1'b0;
		end else if (run_rise && !scan_tick) begin
			run_pending_reg <= 1'b1;
		end else if (scan_tick) begin
			run_pending_reg <= 1'b0;
		end
	end

	// Contact result per channel by its rung position and edge polarity
	genvar c;
	generate
		for (c = 0; c < NUM_CH; c++) begin : g_contact
			logic hit_next;

			// Fall-selected contacts watch the fall strobe, others the rise
			assign edge_hit[c] = ch_fall_sel[c] ? ed.fall[c] : ed.rise[c];

			// An undefined position code leaves the contact open
			always_comb begin
				case (ch_kind[c])
					KIND_START: begin
						hit_next = edge_hit[c];
					end
					KIND_PARALLEL: begin
						hit_next = ch_branch[c] | edge_hit[c];
					end
					KIND_SERIES: begin
						hit_next = ch_branch[c] & edge_hit[c];
					end
					default: begin
						hit_next = 1'b0;
					end
				endcase
			end
			assign contact_next[c] = hit_next;
		end
	endgenerate

	// Held for the whole scan so a pulse lasts exactly one scan
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			contact_reg <= '0;
		end else if (scan_tick) begin
			contact_reg <= contact_next;
		end
	end

	// Timer and counter status cannot be latched on
	assign class_refused = latch_set
		&& (latch_class == PT_TIMER || latch_class == PT_COUNTER);

	// Range and pause masks, inclusive of both ends
	genvar p;
	generate
		for (p = 0; p < NUM_POINTS; p++) begin : g_point
			assign latch_mask[p] = (PT_W'(p) >= latch_start) && (PT_W'(p) <= latch_end);
			assign set_allow[p]  = !(latch_class == PT_INPUT && input_mapped[p]);
			assign pause_mask[p] = pause_rung
				&& (PT_W'(p) >= pause_start) && (PT_W'(p) <= pause_end);

			// Override wins over pause for this point only
			assign hold_off[p]  = pause_mask[p] & ~pause_override[p];
			// Only the terminal is blanked; the image point is left alone
			assign phys_next[p] = point_reg[p] & ~hold_off[p];
		end
	endgenerate

	// Latched points change only on an operation, never on a false rung
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			point_reg <= POINTS_RESET;
		end else if (latch_valid && !class_refused) begin
			if (latch_set) begin
				point_reg <= point_reg | (latch_mask & set_allow);
			end else begin
				point_reg <= point_reg & ~latch_mask;
			end
		end
	end

	// Refusal shows for one cycle; mapped inputs in a set range also count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_reject_reg <= 1'b0;
		end else begin
			latch_reject_reg <= latch_valid && (class_refused
				|| (latch_set && |(latch_mask & ~set_allow)));
		end
	end

	// Bit index arrives as two BCD digits, only 00 to 15 are legal
	assign bcd_tens  = wbit_bcd[BCD_W-1:BCD_DIGIT_W];
	assign bcd_units = wbit_bcd[BCD_DIGIT_W-1:0];
	assign bcd_ok    = (bcd_units <= BCD_MAX_DIGIT)
		&& ((bcd_tens == BCD_ZERO)
		|| (bcd_tens == BCD_TENS_MAX && bcd_units <= BCD_UNITS_MAX));
	assign bit_idx   = (bcd_tens == BCD_TENS_MAX) ? BIT_IDX_W'(bcd_units + BCD_TEN)
		: BIT_IDX_W'(bcd_units);

	// An op only counts with a legal index; a bad one touches no word
	assign wbit_go = wbit_valid && bcd_ok;

	// One-hot mask of the addressed bit
	genvar b;
	generate
		for (b = 0; b < WORD_W; b++) begin : g_bit
			assign bit_sel[b] = (bit_idx == BIT_IDX_W'(b));
		end
	endgenerate

	// Each word holds its own bits; only the addressed bit moves
	genvar w;
	generate
		for (w = 0; w < NUM_WORDS; w++) begin : g_word
			assign word_hit[w] = wbit_go && (wbit_word == WORD_IDX_W'(w));

			// Bits stay as left when the rung goes false
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					word_reg[w] <= WORD_RESET;
				end else if (word_hit[w]) begin
					if (wbit_set) begin
						word_reg[w] <= word_reg[w] | bit_sel;
					end else begin
						word_reg[w] <= word_reg[w] & ~bit_sel;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wbit_reject_reg <= 1'b0;
		end else begin
			wbit_reject_reg <= wbit_valid && !bcd_ok;
		end
	end

	// Output update once per scan; the image keeps running under pause
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phys_reg <= '0;
		end else if (scan_tick) begin
			phys_reg <= phys_next;
		end
	end

	assign contact_out  = contact_reg;
	assign point_state  = point_reg;
	assign latch_reject = latch_reject_reg;
	assign word_data    = word_reg;
	assign wbit_reject  = wbit_reject_reg;
	assign phys_out     = phys_reg;
endmodule

/* File: sim/output_bank.sv */
// Model of the discrete output modules behind the physical outputs.
module output_bank
	import scan_logic_pkg::*;
(
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire logic                  scan_tick,
	input wire logic [NUM_POINTS-1:0] phys_out,
	output logic     [NUM_POINTS-1:0] seen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tick_reg;
	// Terminals follow one cycle after the scan, once outputs have settled
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_reg <= 1'b0;
			seen <= '0;
		end else begin
			tick_reg <= scan_tick;
			if (tick_reg) seen <= phys_out;
		end
	end
endmodule

/* File: sim/scan_logic_props.sv */
// Checker on the scan logic ports.
module scan_logic_props
	import scan_logic_pkg::*;
(
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire logic                  scan_tick,
	input wire logic                  pause_rung,
	input wire logic                  latch_valid,
	input wire logic                  latch_set,
	input point_class_type            latch_class,
	input wire logic                  wbit_valid,
	input wire logic [BCD_W-1:0]      wbit_bcd,
	input logic      [NUM_CH-1:0]     contact_out,
	input logic      [NUM_POINTS-1:0] point_state,
	input logic                       latch_reject,
	input logic                       wbit_reject,
	input logic      [NUM_POINTS-1:0] phys_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Set on timer or counter operands
	sequence tc_set_s;
		latch_valid && latch_set && (latch_class == PT_TIMER || latch_class == PT_COUNTER);
	endsequence
	// Whole op dropped, refusal flagged
	sequence refused_s;
		latch_reject && $stable(point_state);
	endsequence
	contact_hold_a: assert property (!scan_tick |=> $stable(contact_out))
		else $error("contact result moved off scan");
	phys_hold_a: assert property (!scan_tick |=> $stable(phys_out))
		else $error("outputs moved off scan");
	phys_image_a: assert property (scan_tick && !pause_rung |=> phys_out == $past(point_state))
		else $error("outputs differ from image");
	phys_subset_a: assert property (scan_tick |=> (phys_out & ~$past(point_state)) == '0)
		else $error("output on without image");
	tc_refuse_a: assert property (tc_set_s |=> refused_s)
		else $error("timer or counter set taken");
	reset_quiet_a: assert property (latch_valid && !latch_set |=> !latch_reject)
		else $error("reset refused");
	state_keep_a: assert property (!latch_valid |=> $stable(point_state) && !latch_reject)
		else $error("image moved with no op");
	bcd_refuse_a: assert property (wbit_valid && (wbit_bcd[3:0] > 4'h9 || wbit_bcd > 8'h15)
		|=> wbit_reject)
		else $error("illegal bit index taken");
endmodule

bind scan_logic scan_logic_props chk (.clk, .rst_n, .scan_tick, .pause_rung, .latch_valid,
	.latch_set, .latch_class, .wbit_valid, .wbit_bcd, .contact_out, .point_state,
	.latch_reject, .wbit_reject, .phys_out);

/* File: sim/tb_top.sv */
// Bench for the scan edge, latch and pause logic.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import scan_logic_pkg::*;
	logic clk = 0, rst_n = 0, scan_tick = 0, run_mode = 0, latch_valid = 0, latch_set = 0;
	logic wbit_valid = 0, wbit_set = 0, pause_rung = 0, latch_reject, wbit_reject;
	logic [NUM_CH-1:0] ch_point = '0, ch_fall_sel = 8'h2a, ch_branch = '0;
	logic [NUM_CH-1:0] ch_retentive = 8'h40, contact_out;
	contact_kind_type ch_kind [NUM_CH];
	point_class_type latch_class = PT_OUTPUT;
	logic [PT_W-1:0] latch_start = '0, latch_end = '0, pause_start = '0, pause_end = '0;
	logic [NUM_POINTS-1:0] input_mapped = 64'h200, pause_override = 64'h20;
	logic [NUM_POINTS-1:0] point_state, phys_out, seen;
	logic [WORD_IDX_W-1:0] wbit_word = '0;
	logic [BCD_W-1:0] wbit_bcd = '0;
	logic [WORD_W-1:0] word_data [NUM_WORDS];
	int fail_count = 0, samples_checked = 0;

	always #4 clk = ~clk;
	scan_logic dut (
		.clk            (clk),
		.rst_n          (rst_n),
		.scan_tick      (scan_tick),
		.run_mode       (run_mode),
		.ch_point       (ch_point),
		.ch_fall_sel    (ch_fall_sel),
		.ch_branch      (ch_branch),
		.ch_retentive   (ch_retentive),
		.ch_kind        (ch_kind),
		.contact_out    (contact_out),
		.latch_valid    (latch_valid),
		.latch_set      (latch_set),
		.latch_class    (latch_class),
		.latch_start    (latch_start),
		.latch_end      (latch_end),
		.input_mapped   (input_mapped),
		.point_state    (point_state),
		.latch_reject   (latch_reject),
		.wbit_valid     (wbit_valid),
		.wbit_set       (wbit_set),
		.wbit_word      (wbit_word),
		.wbit_bcd       (wbit_bcd),
		.word_data      (word_data),
		.wbit_reject    (wbit_reject),
		.pause_rung     (pause_rung),
		.pause_start    (pause_start),
		.pause_end      (pause_end),
		.pause_override (pause_override),
		.phys_out       (phys_out)
	);
	output_bank bank (.clk, .rst_n, .scan_tick, .phys_out, .seen);

	task automatic check(input string what, input logic [63:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// One scan; result stands the cycle after the tick
	task automatic scan(input logic [7:0] pt, br, exp);
		@(negedge clk);
		ch_point = pt;
		ch_branch = br;
		scan_tick = 1'b1;
		@(negedge clk);
		scan_tick = 1'b0;
		check("contact_out", {56'h0, exp}, {56'h0, contact_out});
	endtask
	task automatic op(input logic s, point_class_type c, logic [5:0] a, b, logic [63:0] e,
		logic r);
		@(negedge clk);
		latch_valid = 1'b1;
		latch_set = s;
		latch_class = c;
		latch_start = a;
		latch_end = b;
		@(negedge clk);
		latch_valid = 1'b0;
		check("point_state", e, point_state);
		check("latch_reject", {63'h0, r}, {63'h0, latch_reject});
	endtask
	task automatic wop(input logic s, logic [2:0] w, logic [7:0] d, logic [15:0] e, logic r);
		@(negedge clk);
		wbit_valid = 1'b1;
		wbit_set = s;
		wbit_word = w;
		wbit_bcd = d;
		@(negedge clk);
		wbit_valid = 1'b0;
		check("word_data", {48'h0, e}, {48'h0, word_data[w]});
		check("wbit_reject", {63'h0, r}, {63'h0, wbit_reject});
	endtask
	task automatic t_edge;
		scan(8'h40, 8'h00, 8'h40);
		scan(8'h40, 8'h00, 8'h00);
		run_mode = 1'b1;
		repeat (2) @(negedge clk);
		scan(8'h40, 8'h00, 8'h40);
		scan(8'h40, 8'h00, 8'h00);
		scan(8'hff, 8'h10, 8'h95);
		scan(8'h00, 8'ha0, 8'haa);
		scan(8'h00, 8'h88, 8'h88);
		scan(8'h30, 8'h00, 8'h00);
		$display("edge test done");
	endtask
	task automatic t_latch;
		op(1, PT_OUTPUT, 2, 5, 64'h3c, 0);
		op(0, PT_RELAY, 3, 3, 64'h34, 0);
		op(1, PT_TIMER, 0, 63, 64'h34, 1);
		op(1, PT_COUNTER, 0, 63, 64'h34, 1);
		op(1, PT_INPUT, 8, 11, 64'hd34, 1);
		op(1, PT_STAGE, 9, 8, 64'hd34, 0);
		repeat (3) @(negedge clk);
		check("point_state", 64'hd34, point_state);
		$display("latch test done");
	endtask
	task automatic t_wbit;
		wop(1, 0, 8'h12, 16'h1000, 0);
		wop(1, 3, 8'h15, 16'h8000, 0);
		wop(1, 3, 8'h00, 16'h8001, 0);
		wop(0, 3, 8'h15, 16'h0001, 0);
		wop(1, 3, 8'h16, 16'h0001, 1);
		wop(1, 3, 8'h0a, 16'h0001, 1);
		check("word_data", {48'h0, 16'h1000}, {48'h0, word_data[0]});
		$display("word bit test done");
	endtask
	// Pause 4..10 with point 5 exempt; image must keep moving underneath
	task automatic t_pause;
		pause_start = 6'h04;
		pause_end = 6'h0a;
		pause_rung = 1'b1;
		scan(8'h30, 8'h00, 8'h00);
		@(negedge clk);
		check("seen", 64'h824, seen);
		check("point_state", 64'hd34, point_state);
		op(1, PT_OUTPUT, 6, 6, 64'hd74, 0);
		scan(8'h30, 8'h00, 8'h00);
		@(negedge clk);
		check("seen", 64'h824, seen);
		check("phys_out", 64'h824, phys_out);
		pause_rung = 1'b0;
		scan(8'h30, 8'h00, 8'h00);
		@(negedge clk);
		check("seen", 64'hd74, seen);
		check("phys_out", 64'hd74, phys_out);
		$display("pause test done");
	endtask
	// Mid-run reset clears all state; edges then start from a clean history
	task automatic t_reset;
		@(negedge clk);
		rst_n = 1'b0;
		@(negedge clk);
		check("point_state", 64'h0, point_state);
		check("phys_out", 64'h0, phys_out);
		check("word_data", 64'h0, {48'h0, word_data[0]});
		check("contact_out", 64'h0, {56'h0, contact_out});
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		scan(8'h41, 8'h00, 8'h41);
		$display("reset test done");
	endtask

	initial begin
		ch_kind = '{KIND_START, KIND_START, KIND_PARALLEL, KIND_PARALLEL, KIND_SERIES,
			KIND_SERIES, KIND_START, KIND_PARALLEL};
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		t_edge();
		t_latch();
		t_wbit();
		t_pause();
		t_reset();
		close_out();
	end
	// Hang guard
	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		close_out();
	end
endmodule
